/* File: hw/tsl_pkg.sv */
package tsl_pkg;
    localparam int CLK_MHZ          = 100;
    // time figures in their own units
    localparam int SPI_READY_MS     = 50;
    localparam int FULL_READY_MS    = 400;
    localparam int GAP_US           = 500;
    localparam int GRACE_US         = 20;
    localparam int XFER_TIMEOUT_MS  = 10;
    localparam int CAL_BURSTS       = 15;
    // derived cycle counts
    localparam int SPI_READY_CYC    = SPI_READY_MS * 1000 * CLK_MHZ;
    localparam int FULL_READY_CYC   = FULL_READY_MS * 1000 * CLK_MHZ;
    localparam int GAP_CYC          = GAP_US * CLK_MHZ;
    localparam int GRACE_CYC        = GRACE_US * CLK_MHZ;
    localparam int XFER_TIMEOUT_CYC = XFER_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int BURST_CYC        = 1000;
    localparam int PROC_CYC         = 200;
    localparam int BYTES_PER_XFER   = 3;
    localparam int NUM_CH           = 10;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [4:0] {
        TSL_ST_INIT  = 5'h01,
        TSL_ST_BURST = 5'h02,
        TSL_ST_GAP   = 5'h04,
        TSL_ST_PROC  = 5'h08,
        TSL_ST_HOLD  = 5'h10
    } tsl_state_t;

    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
    } tsl_spi_in_t;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } tsl_frame_t;

    typedef struct packed {
        logic spread_en;
        logic lockout_en;
        logic [2:0] low_power_interval_code;
        logic thresh_custom;
    } tsl_cfg_t;
endpackage

/* File: hw/tsl_spi_shift.sv */
module tsl_spi_shift
    import tsl_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            active_i,
    input  wire logic            sck_i,
    input  wire logic            ss_n_i,
    input  wire logic            mosi_i,
    input  wire logic            abort_i,
    input  wire tsl_frame_t      tx_i,
    output logic                 miso_o,
    output logic                 byte_done_o,
    output logic [1:0]           byte_idx_o,
    output tsl_frame_t           rx_o,
    output logic                 frame_done_o,
    output logic                 first_edge_o
);
    logic       sck_q;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic       rise;
    logic       fall;
    logic [7:0] cur_byte;

    function automatic logic [7:0] pick(input tsl_frame_t f, input logic [1:0] i);
        case (i)
            2'h0:    pick = f.b1;
            2'h1:    pick = f.b2;
            default: pick = f.b3;
        endcase
    endfunction

    assign rise = active_i && !ss_n_i && sck_i && !sck_q;
    assign fall = active_i && !ss_n_i && !sck_i && sck_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_i;
        end
    end

    // ss may rise between bytes, so the index survives it
    always_ff @(posedge clk_i) begin
        byte_done_o  <= 1'b0;
        frame_done_o <= 1'b0;
        first_edge_o <= 1'b0;
        if (!rst_n_i || abort_i) begin
            bit_cnt    <= 3'h0;
            byte_idx_o <= 2'h0;
            sh_in      <= 8'h00;
            sh_out     <= pick(tx_i, 2'h0);
            rx_o       <= '0;
        end else if (rise) begin
            sh_in   <= {sh_in[6:0], mosi_i};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h0 && byte_idx_o == 2'h0) begin
                first_edge_o <= 1'b1;
            end
            if (bit_cnt == 3'h7) begin
                byte_done_o <= 1'b1;
                case (byte_idx_o)
                    2'h0:    rx_o.b1 <= {sh_in[6:0], mosi_i};
                    2'h1:    rx_o.b2 <= {sh_in[6:0], mosi_i};
                    default: rx_o.b3 <= {sh_in[6:0], mosi_i};
                endcase
                if (byte_idx_o == 2'(BYTES_PER_XFER - 1)) begin
                    byte_idx_o   <= 2'h0;
                    frame_done_o <= 1'b1;
                end else begin
                    byte_idx_o <= byte_idx_o + 2'h1;
                end
            end
        end else if (fall) begin
            if (bit_cnt == 3'h0) begin
                sh_out <= pick(tx_i, byte_idx_o);
            end else begin
                sh_out <= {sh_out[6:0], 1'b0};
            end
        end else if (ss_n_i && bit_cnt == 3'h0) begin
            sh_out <= pick(tx_i, byte_idx_o);
        end
    end

    // between bytes the next byte's first bit shows before any falling edge
    assign cur_byte = pick(tx_i, byte_idx_o);
    assign miso_o   = (bit_cnt == 3'h0) ? cur_byte[7] : sh_out[7];
endmodule

/* File: hw/tsl_link.sv */
// Overview of operation
// - outputs undriven while reset held
// - after reset: ready low, change high
// - serial port live after start-up delay
// - change stays high until status read
// - calibrate over 15 burst sets, no touches
// - touch results valid after 400 ms
// - out-of-range channels disabled, rechecked on recal
// - start free-running, lockout off
// - ready low in burst, high 500 us between
// - ready high while idle unless exchanged
// - after third byte ready low until burst end
// - early exchange raises ready, defers bursts
// - three bytes within 10 ms else reset
// - exchange is exactly three bytes
// - sample rising, shift falling
// - low select blocks deep sleep
// - change rises when status changes
// - change rises when threshold or interval setting applied
// - change falls only after exchange read
// - spread input selects spread bursts
// - three bursts: 3 keys, 4 keys, 3 wheel
// - settings take effect after burst set
module tsl_link
    import tsl_pkg::*;
#(
    parameter int SPI_READY_P  = SPI_READY_CYC,
    parameter int FULL_READY_P = FULL_READY_CYC,
    parameter int GAP_P        = GAP_CYC,
    parameter int TIMEOUT_P    = XFER_TIMEOUT_CYC
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire tsl_spi_in_t       spi_i,
    input  wire logic              spread_sel_i,
    input  wire logic [6:0]        key_raw_i,
    input  wire logic [7:0]        slider_pos_i,
    input  wire logic [NUM_CH-1:0] ch_in_range_i,
    input  wire logic              recal_i,
    output logic                   miso_o,
    output logic                   miso_oe_o,
    output logic                   burst_idle_flag_o,
    output logic                   burst_idle_flag_oe_o,
    output logic                   change_o,
    output logic                   change_oe_o,
    output logic [1:0]             burst_group_o,
    output logic                   bursting_o,
    output logic                   spread_en_o,
    output logic                   deep_sleep_ok_o,
    output logic                   touch_valid_o,
    output logic [NUM_CH-1:0]      ch_enabled_o,
    output tsl_cfg_t               cfg_o
);
    tsl_spi_in_t    spi_m;
    tsl_spi_in_t    spi_s;
    tsl_state_t     state;
    logic [31:0]    timer;
    logic [31:0]    up_cnt;
    logic [31:0]    xfer_cnt;
    logic [3:0]     burst_sets;
    logic [1:0]     grp;
    logic           spi_live;
    logic           cal_done;
    logic           xfer_open;
    logic           exchanged;
    logic           grace_hold;
    logic           abort;
    logic           miso_raw;
    tsl_frame_t     rx;
    tsl_frame_t     tx;
    logic           frame_done;
    logic           first_edge;
    tsl_cfg_t       cfg_pend;
    logic           cfg_new;
    logic [14:0]    status_q;
    logic [14:0]    status_now;
    logic           spread_m;
    logic           spread_s;

    // two-flop sync of everything from the pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            spi_m    <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};
            spi_s    <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};
            spread_m <= 1'b0;
            spread_s <= 1'b0;
        end else begin
            spi_m    <= spi_i;
            spi_s    <= spi_m;
            spread_m <= spread_sel_i;
            spread_s <= spread_m;
        end
    end

    assign status_now = {touch_valid_o ? key_raw_i : 7'h00, slider_pos_i};
    assign tx = '{b1: {1'b0, status_now[14:8]}, b2: status_now[7:0], b3: {2'h0, cfg_o}};
    assign abort = xfer_open && xfer_cnt >= 32'(TIMEOUT_P - 1);

    tsl_spi_shift u_shift (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .active_i     (spi_live),
        .sck_i        (spi_s.sck),
        .ss_n_i       (spi_s.ss_n),
        .mosi_i       (spi_s.mosi),
        .abort_i      (abort),
        .tx_i         (tx),
        .miso_o       (miso_raw),
        .byte_done_o  (),
        .byte_idx_o   (),
        .rx_o         (rx),
        .frame_done_o (frame_done),
        .first_edge_o (first_edge)
    );

    // start-up milestones counted from reset release
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            up_cnt        <= 32'h0000_0000;
            spi_live      <= 1'b0;
            touch_valid_o <= 1'b0;
        end else begin
            if (up_cnt != 32'hFFFF_FFFF) begin
                up_cnt <= up_cnt + 32'h0000_0001;
            end
            if (up_cnt >= 32'(SPI_READY_P - 1)) begin
                spi_live <= 1'b1;
            end
            if (up_cnt >= 32'(FULL_READY_P - 1) && cal_done) begin
                touch_valid_o <= 1'b1;
            end
        end
    end

    // timeout runs from the first bit of byte one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || abort || frame_done) begin
            xfer_open <= 1'b0;
            xfer_cnt  <= 32'h0000_0000;
        end else if (first_edge) begin
            xfer_open <= 1'b1;
            xfer_cnt  <= 32'h0000_0000;
        end else if (xfer_open) begin
            xfer_cnt <= xfer_cnt + 32'h0000_0001;
        end
    end

    // acquisition sequencer; the gap timer also measures the grace window
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state      <= TSL_ST_INIT;
            timer      <= 32'h0000_0000;
            grp        <= 2'h0;
            burst_sets <= 4'h0;
            cal_done   <= 1'b0;
            grace_hold <= 1'b0;
        end else begin
            timer <= timer + 32'h0000_0001;
            case (state)
                TSL_ST_INIT: begin
                    state <= TSL_ST_BURST;
                    timer <= 32'h0000_0000;
                end
                TSL_ST_BURST: begin
                    if (first_edge && timer < 32'(GRACE_CYC)) begin
                        state      <= TSL_ST_HOLD;
                        grace_hold <= 1'b1;
                    end else if (timer >= 32'(BURST_CYC - 1)) begin
                        timer <= 32'h0000_0000;
                        if (grp == 2'h2) begin
                            grp   <= 2'h0;
                            state <= TSL_ST_PROC;
                            if (burst_sets != 4'(CAL_BURSTS)) begin
                                burst_sets <= burst_sets + 4'h1;
                            end
                            if (burst_sets == 4'(CAL_BURSTS - 1)) begin
                                cal_done <= 1'b1;
                            end
                        end else begin
                            grp   <= grp + 2'h1;
                            state <= TSL_ST_GAP;
                        end
                    end
                end
                TSL_ST_GAP: begin
                    if (timer >= 32'(GAP_P - 1)) begin
                        timer <= 32'h0000_0000;
                        state <= TSL_ST_BURST;
                    end
                end
                TSL_ST_PROC: begin
                    if (timer >= 32'(PROC_CYC - 1)) begin
                        timer <= 32'h0000_0000;
                        state <= TSL_ST_BURST;
                    end
                end
                TSL_ST_HOLD: begin
                    if (frame_done || abort) begin
                        grace_hold <= 1'b0;
                        timer      <= 32'h0000_0000;
                        state      <= TSL_ST_BURST;
                    end
                end
                default: begin
                    state <= TSL_ST_INIT;
                end
            endcase
        end
    end

    // exchange since last burst pulls the idle flag low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            exchanged <= 1'b0;
        end else if (frame_done && !grace_hold) begin
            exchanged <= 1'b1;
        end else if (state == TSL_ST_BURST && timer >= 32'(BURST_CYC - 1)) begin
            exchanged <= 1'b0;
        end
    end

    // settings wait for the current burst set to end before use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_pend <= '{spread_en: 1'b0, lockout_en: 1'b0,
                          low_power_interval_code: 3'h0, thresh_custom: 1'b0};
            cfg_o    <= '{spread_en: 1'b0, lockout_en: 1'b0,
                          low_power_interval_code: 3'h0, thresh_custom: 1'b0};
            cfg_new  <= 1'b0;
        end else begin
            if (frame_done) begin
                cfg_pend <= rx.b1[5:0];
                cfg_new  <= 1'b1;
            end else if (state == TSL_ST_PROC && timer == 32'h0000_0000 && cfg_new) begin
                cfg_o   <= cfg_pend;
                cfg_new <= 1'b0;
            end
        end
    end

    // change: hardware set wins over the read clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            status_q <= 15'h0000;
            change_o <= 1'b0;
        end else if (state == TSL_ST_INIT) begin
            change_o <= 1'b1;
        end else begin
            status_q <= status_now;
            if (status_q != status_now && touch_valid_o) begin
                change_o <= 1'b1;
            end else if (state == TSL_ST_PROC && timer == 32'h0000_0000 && cfg_new
                         && (cfg_pend.thresh_custom
                             || cfg_pend.low_power_interval_code
                                != cfg_o.low_power_interval_code)) begin
                change_o <= 1'b1;
            end else if (frame_done) begin
                change_o <= 1'b0;
            end
        end
    end

    // channel enables re-examined at each calibration pass
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ch_enabled_o <= '0;
        end else if (recal_i || (!cal_done && state == TSL_ST_PROC)) begin
            ch_enabled_o <= ch_in_range_i;
        end
    end

    // pin drivers, all registered; every enable off in reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            burst_idle_flag_o    <= 1'b0;
            burst_idle_flag_oe_o <= 1'b0;
            change_oe_o          <= 1'b0;
            miso_o               <= 1'b0;
            miso_oe_o            <= 1'b0;
            burst_group_o        <= 2'h0;
            bursting_o           <= 1'b0;
            spread_en_o          <= 1'b0;
            deep_sleep_ok_o      <= 1'b0;
        end else begin
            burst_idle_flag_oe_o <= 1'b1;
            change_oe_o          <= 1'b1;
            burst_idle_flag_o    <= grace_hold
                                 || (!exchanged && state != TSL_ST_BURST
                                     && state != TSL_ST_INIT);
            miso_o               <= miso_raw;
            miso_oe_o            <= spi_live && !spi_s.ss_n;
            burst_group_o        <= grp;
            bursting_o           <= state == TSL_ST_BURST;
            spread_en_o          <= spread_s;
            deep_sleep_ok_o      <= spi_s.ss_n && state == TSL_ST_PROC;
        end
    end
endmodule

/* File: tb/tsl_link_chk.sv */
module tsl_link_chk
    import tsl_pkg::*;
#(
    parameter int SPI_READY_P  = 200,
    parameter int FULL_READY_P = 20000
)
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire tsl_spi_in_t spi_i,
    input wire logic        spread_sel_i,
    input wire logic        miso_oe_o,
    input wire logic        burst_idle_flag_o,
    input wire logic        burst_idle_flag_oe_o,
    input wire logic        change_o,
    input wire logic        change_oe_o,
    input wire logic [1:0]  burst_group_o,
    input wire logic        bursting_o,
    input wire logic        spread_en_o,
    input wire logic        deep_sleep_ok_o,
    input wire logic        touch_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int         since_rst;
    logic [7:0] since_sel;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // saturating counts keep the helper small over long runs
    always_ff @(posedge clk_i) begin
        since_rst <= !rst_n_i ? 0 : (since_rst < FULL_READY_P ? since_rst + 1 : since_rst);
    end
    always_ff @(posedge clk_i) begin
        since_sel <= !spi_i.ss_n ? 8'h00 : (since_sel == 8'hFF ? since_sel : since_sel + 8'h01);
    end

    sequence s_release;
        !rst_n_i ##1 rst_n_i [*2];
    endsequence
    sequence s_spread_settled;
        $changed(spread_sel_i) ##1 $stable(spread_sel_i) [*5];
    endsequence

    a_oe_in_reset: assert property (disable iff (1'b0)
        !rst_n_i |=> !miso_oe_o && !change_oe_o && !burst_idle_flag_oe_o)
        else $error("output enabled during reset");
    a_start_levels: assert property (disable iff (1'b0)
        s_release |=> change_oe_o && change_o && burst_idle_flag_oe_o && !burst_idle_flag_o)
        else $error("wrong start-up levels");
    a_spi_late: assert property (
        since_rst < SPI_READY_P - 1 |-> !miso_oe_o)
        else $error("serial port live too early");
    a_flag_in_burst: assert property (
        bursting_o |-> !burst_idle_flag_o)
        else $error("idle flag high during burst");
    a_flag_after_burst: assert property (
        $fell(bursting_o) |-> burst_idle_flag_o)
        else $error("idle flag low after burst");
    a_group_order: assert property (
        $changed(burst_group_o) && $past(rst_n_i) |-> burst_group_o ==
        (($past(burst_group_o) == 2'h2) ? 2'h0 : $past(burst_group_o) + 2'h1))
        else $error("burst group out of order");
    a_change_read: assert property (
        $fell(change_o) && $past(rst_n_i) |-> since_sel < 8'h28)
        else $error("change fell without exchange");
    a_spread_follow: assert property (
        s_spread_settled |-> spread_en_o == spread_sel_i)
        else $error("spread enable not following input");
    a_touch_late: assert property (
        touch_valid_o |-> since_rst >= FULL_READY_P - 2)
        else $error("touch valid too early");
    a_sel_wakes: assert property (
        (!spi_i.ss_n) [*4] |-> !deep_sleep_ok_o)
        else $error("deep sleep allowed while selected");
    a_miso_float: assert property (
        spi_i.ss_n [*6] |-> !miso_oe_o)
        else $error("data out driven while deselected");
endmodule

/* File: tb/tsl_host_model.sv */
module tsl_host_model
    import tsl_pkg::*;
(
    output tsl_spi_in_t spi_o,
    input  wire logic   miso_i
);
    timeunit 1ns;
    timeprecision 1ps;

    event frame_done;

    // clock idles low and stands still between frames
    initial spi_o = '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};

    task automatic xfer(input logic [23:0] tx, input int nbytes, input bit split,
                        output logic [23:0] rx);
        rx = '0;
        spi_o.ss_n = 1'b0;
        #2000; // free-running select-to-clock wait
        for (int i = 0; i < nbytes * 8; i++) begin
            if (split && i > 0 && i % 8 == 0) begin // select released between bytes
                spi_o.ss_n = 1'b1;
                #500;
                spi_o.ss_n = 1'b0;
                #2000;
            end
            spi_o.mosi = tx[23 - i]; // msb first, shifted after the falling edge
            #80 spi_o.sck = 1'b1;
            rx[23 - i] = miso_i;
            #80 spi_o.sck = 1'b0;
        end
        #80 spi_o.ss_n = 1'b1; // idle host keeps select high
        spi_o.mosi = ~spi_o.mosi; // a released line must not show the last bit
        if (nbytes == 3) -> frame_done;
    endtask
endmodule

/* File: tb/tsl_link_test.sv */
module tsl_link_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tsl_pkg::*;

    localparam int READY = 200;
    localparam int FULL  = 20000;
    localparam int TOUT  = 5000;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    tsl_spi_in_t       spi;
    logic              spread_sel = 1'b0;
    logic [6:0]        key_raw = 7'h00;
    logic [7:0]        slider_pos = 8'h00;
    logic [NUM_CH-1:0] ch_range = '0;
    logic              recal = 1'b0;
    logic              miso, miso_oe, flag, flag_oe, chg, chg_oe;
    logic              bursting, spread_en, sleep_ok, touch_ok;
    logic [1:0]        group;
    logic [NUM_CH-1:0] ch_en;
    tsl_cfg_t          cfg;
    wire logic         miso_w;
    int                errors = 0;
    int                cmp_count = 0;
    int                seed = 53698;
    logic [1:0]        exp_q [$];

    always #5 clk = ~clk;
    assign miso_w = miso_oe ? miso : 1'bz;

    tsl_link #(.SPI_READY_P(READY), .FULL_READY_P(FULL), .GAP_P(50), .TIMEOUT_P(TOUT)) dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .spi_i(spi), .spread_sel_i(spread_sel),
        .key_raw_i(key_raw), .slider_pos_i(slider_pos), .ch_in_range_i(ch_range),
        .recal_i(recal), .miso_o(miso), .miso_oe_o(miso_oe), .burst_idle_flag_o(flag),
        .burst_idle_flag_oe_o(flag_oe), .change_o(chg), .change_oe_o(chg_oe),
        .burst_group_o(group), .bursting_o(bursting), .spread_en_o(spread_en),
        .deep_sleep_ok_o(sleep_ok), .touch_valid_o(touch_ok), .ch_enabled_o(ch_en),
        .cfg_o(cfg));

    tsl_host_model host_u (.spi_o(spi), .miso_i(miso_w));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic [7:0] b1, input bit split);
        logic [23:0] rx;
        exp_q.push_back(2'h0);
        host_u.xfer({b1, 16'h0000}, 3, split, rx);
        // the watcher looks before anything else moves, and select stays high a while
        tick(8);
        check("status byte two", rx[15:8], slider_pos);
    endtask

    task automatic test_done;
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a read clears change and the idle flag stays low until the next burst ends
    initial begin
        forever begin
            @(host_u.frame_done);
            tick(4);
            check("change and flag", {chg, flag}, exp_q.pop_front());
        end
    end

    initial begin
        #950_000;
        errors++;
        test_done();
    end

    initial begin
        int          n;
        time         t0;
        logic [23:0] rx;
        ch_range = NUM_CH'($random(seed)) | 10'h001;
        key_raw = 7'($random(seed));
        slider_pos = 8'($random(seed));
        tick(2);
        rst_n = 1'b1;
        t0 = $time;
        tick(2);
        check("start levels", {chg_oe, chg, flag_oe, flag}, 4'hE);
        check("start mode", {cfg.lockout_en, cfg.low_power_interval_code}, 4'h0);
        check("touch valid at start", touch_ok, 1'b0);
        tick(READY);
        frame(8'h00, 1'b0);
        key_raw = ~key_raw;
        tick(2000);
        check("change during calibration", chg, 1'b0);
        for (n = 0; n < 80000 && touch_ok !== 1'b1; n++) tick();
        check("touch valid", touch_ok, 1'b1);
        check("touch delay", ($time - t0) >= FULL * 10, 1'b1);
        check("channels enabled", ch_en, ch_range);
        key_raw = ~key_raw;
        for (n = 0; n < 20000 && chg !== 1'b1; n++) tick();
        check("change on key", chg, 1'b1);
        frame(8'h00, 1'b1);
        // bit 0 always flips, so the key state really changes
        key_raw = key_raw ^ (7'($random(seed)) | 7'h01);
        for (n = 0; n < 20000 && chg !== 1'b1; n++) tick();
        check("change on new key", chg, 1'b1);
        // two bytes, silence, then one byte: a stale index would finish the frame here
        host_u.xfer(24'hFFFFFF, 2, 1'b0, rx);
        tick(TOUT + 100);
        host_u.xfer(24'h000000, 1, 1'b0, rx);
        tick(20);
        check("change after stale bytes", chg, 1'b1);
        tick(TOUT + 100);
        frame(8'h00, 1'b0);
        frame(8'h11, 1'b0);
        check("cfg before burst set", cfg.lockout_en, 1'b0);
        for (n = 0; n < 20000 && chg !== 1'b1; n++) tick();
        check("change on setting", chg, 1'b1);
        check("applied cfg", cfg, 6'h11);
        for (int i = 0; i < 4; i++) begin
            spread_sel = ~spread_sel;
            tick(8);
            check("spread enable", spread_en, spread_sel);
        end
        ch_range = ~ch_range;
        recal = 1'b1;
        tick();
        recal = 1'b0;
        for (n = 0; n < 20000 && ch_en !== ch_range; n++) tick();
        check("channels after recal", ch_en, ch_range);
        tick(20);
        test_done();
    end
endmodule

bind tsl_link tsl_link_chk #(.SPI_READY_P(SPI_READY_P), .FULL_READY_P(FULL_READY_P)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_i(spi_i), .spread_sel_i(spread_sel_i),
    .miso_oe_o(miso_oe_o), .burst_idle_flag_o(burst_idle_flag_o),
    .burst_idle_flag_oe_o(burst_idle_flag_oe_o), .change_o(change_o),
    .change_oe_o(change_oe_o), .burst_group_o(burst_group_o), .bursting_o(bursting_o),
    .spread_en_o(spread_en_o), .deep_sleep_ok_o(deep_sleep_ok_o),
    .touch_valid_o(touch_valid_o));
